// ===== src/clhp_pkg.sv
/*
 package of the character display host port: register map, field layout,
 timing counts and the pin bundle.
 assumes a 25 MHz system clock.
*/
package clhp_pkg;
    // ****************************************
    // bus map
    // ****************************************
    localparam logic [3:0] clhp_adr_ctrl = 4'h0;
    localparam logic [3:0] clhp_adr_cmd = 4'h4;
    localparam logic [3:0] clhp_adr_stat = 4'h8;
    // ctrl fields
    localparam int clhp_ctl_init_bit = 0;
    localparam int clhp_ctl_nib_bit = 1;
    localparam int clhp_ctl_two_bit = 2;
    localparam int clhp_ctl_dual_bit = 3;
    localparam logic [3:0] clhp_ctl_rst = 4'h4;
    // cmd fields
    localparam int clhp_cmd_sel_bit = 8;
    localparam int clhp_cmd_ctl2_bit = 9;
    // stat fields
    localparam int clhp_st_busy_bit = 0;
    localparam int clhp_st_ready_bit = 1;
    localparam int clhp_st_err_bit = 2;
    // ****************************************
    // instruction codes
    // ****************************************
    localparam logic [7:0] clhp_if_base = 8'h30;
    localparam logic [7:0] clhp_if_8bit = 8'h10;
    localparam logic [7:0] clhp_if_two = 8'h08;
    localparam logic [7:0] clhp_entry_inc = 8'h06;
    localparam logic [7:0] clhp_disp_cur = 8'h0e;
    localparam logic [7:0] clhp_clear = 8'h01;
    localparam logic [7:0] clhp_home = 8'h02;
    localparam logic [7:0] clhp_addr_line1 = 8'h80;
    localparam logic [7:0] clhp_addr_line2 = 8'hc0;
    // ****************************************
    // timing
    // ****************************************
    localparam int clhp_clk_khz = 25000;
    localparam int clhp_pwr_us = 15001;
    localparam int clhp_slow_us = 1600;
    localparam int clhp_fast_us = 50;
    localparam int clhp_pulse_ns = 240;
    localparam int clhp_setup_ns = 80;
    localparam int clhp_pwr_cyc = clhp_pwr_us * (clhp_clk_khz / 1000);
    localparam int clhp_slow_cyc = clhp_slow_us * (clhp_clk_khz / 1000);
    localparam int clhp_fast_cyc = clhp_fast_us * (clhp_clk_khz / 1000);
    localparam int clhp_pulse_cyc = (clhp_pulse_ns * clhp_clk_khz + 999999) / 1000000;
    localparam int clhp_setup_cyc = (clhp_setup_ns * clhp_clk_khz + 999999) / 1000000;
    // ****************************************
    // pins toward the module
    // ****************************************
    typedef struct packed {
        logic instr_or_char_select;
        logic write_not_read;
        logic first_pair_strobing;
        logic second_pair_strobing;
        logic [7:0] data;
    } clhp_pins_t;
endpackage

// ===== src/clhp_host.sv
/*
 host controller for a character dot-matrix display: wishbone slave for
 software, parallel write port toward the display module.
 assumes the module is write-only here and its pins are on clk timing.
*/
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - run full init after every reset
// - interface code sent at least twice
// - init uses select low, write low
// - four-bit mode uses upper lines twice
// - one strobe per nibble in 4-bit
// - init is 38 38 06 0e 01 80 in 8-bit two-line mode
// - characters sent with select high
// - wait over 15 ms before the init after reset; a software restart starts init at once
// - wait 1.6 ms after clear/home
// - other entries at least 50 us apart
// - each controller initialised via own strobe
// - idle controller strobe held low
module clhp_host
    import clhp_pkg::*;
#(
    parameter int pwr_cyc = clhp_pwr_cyc,
    parameter int slow_cyc = clhp_slow_cyc,
    parameter int fast_cyc = clhp_fast_cyc
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output clhp_pins_t lcd_pins
);
    // ****************************************
    // state
    // ****************************************
    typedef enum logic [3:0] {
        s_power, s_init_load, s_idle, s_setup, s_pulse, s_hold, s_wait
    } clhp_state_t;

    clhp_state_t state_ff;
    logic [3:0] ctrl_ff;
    logic [9:0] cmd_ff;
    logic cmd_pend_ff;
    logic err_ff;
    logic ready_ff;
    logic [2:0] step_ff;
    logic ctl2_pass_ff;
    logic in_init_ff;
    logic lo_nib_ff;
    logic [23:0] cnt_ff;
    logic [7:0] byte_ff;
    logic sel_ff;
    logic to_ctl2_ff;
    logic [31:0] nxt_rd;

    // delay after a byte: clear/home need the long wait
    function automatic logic [23:0] gap_of(input logic [7:0] b, input logic sel);
        if (!sel && (b == clhp_clear || b == clhp_home))
            return 24'(slow_cyc);
        return 24'(fast_cyc);
    endfunction

    // init step table
    function automatic logic [7:0] init_byte(input logic [2:0] s, input logic [3:0] c);
        logic [7:0] ifc;
        ifc = clhp_if_base;
        if (!c[clhp_ctl_nib_bit])
            ifc = ifc | clhp_if_8bit;
        else
            ifc = ifc & ~clhp_if_8bit;
        if (c[clhp_ctl_two_bit])
            ifc = ifc | clhp_if_two;
        unique case (s)
            3'h0, 3'h1: return ifc;
            3'h2: return clhp_entry_inc;
            3'h3: return clhp_disp_cur;
            3'h4: return clhp_clear;
            default: return clhp_addr_line1;
        endcase
    endfunction

    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_cmd = wb_req && wb_we_i && wb_adr_i == clhp_adr_cmd && wb_sel_i[0];

    // ****************************************
    // wishbone slave
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_req;
    end

    always_comb
    begin
        nxt_rd = 32'h0;
        unique case (wb_adr_i)
            clhp_adr_ctrl: nxt_rd = {28'h0, ctrl_ff};
            clhp_adr_cmd: nxt_rd = {22'h0, cmd_ff};
            clhp_adr_stat: nxt_rd = {29'h0, err_ff, ready_ff, cmd_pend_ff};
            default: nxt_rd = 32'h0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            wb_dat_o <= 32'h0;
        else if (wb_req && !wb_we_i)
            wb_dat_o <= nxt_rd;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            ctrl_ff <= clhp_ctl_rst;
        else if (wb_req && wb_we_i && wb_adr_i == clhp_adr_ctrl && wb_sel_i[0])
            ctrl_ff <= wb_dat_i[3:0];
        else if (state_ff == s_init_load)
            ctrl_ff[clhp_ctl_init_bit] <= 1'b0;
    end

    // commands before init ends are refused and flagged
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cmd_ff <= 10'h0;
            cmd_pend_ff <= 1'b0;
            err_ff <= 1'b0;
        end
        else
        begin
            if (wr_cmd && (cmd_pend_ff || !ready_ff))
                err_ff <= 1'b1;
            else if (wb_req && wb_we_i && wb_adr_i == clhp_adr_stat && wb_dat_i[clhp_st_err_bit])
                err_ff <= 1'b0;
            if (wr_cmd && !cmd_pend_ff && ready_ff)
            begin
                cmd_ff <= wb_dat_i[9:0];
                cmd_pend_ff <= 1'b1;
            end
            else if (state_ff == s_idle && cmd_pend_ff)
                cmd_pend_ff <= 1'b0;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_ff <= s_power;
            cnt_ff <= 24'h0;
            step_ff <= 3'h0;
            ctl2_pass_ff <= 1'b0;
            in_init_ff <= 1'b1;
            ready_ff <= 1'b0;
            lo_nib_ff <= 1'b0;
            byte_ff <= 8'h0;
            sel_ff <= 1'b0;
            to_ctl2_ff <= 1'b0;
        end
        else
        begin
            unique case (state_ff)
                s_power:
                begin
                    if (cnt_ff == 24'(pwr_cyc - 1))
                    begin
                        cnt_ff <= 24'h0;
                        state_ff <= s_init_load;
                    end
                    else
                        cnt_ff <= cnt_ff + 24'h1;
                end
                s_init_load:
                begin
                    in_init_ff <= 1'b1;
                    ready_ff <= 1'b0;
                    byte_ff <= init_byte(step_ff, ctrl_ff);
                    sel_ff <= 1'b0;
                    to_ctl2_ff <= ctl2_pass_ff;
                    lo_nib_ff <= 1'b0;
                    cnt_ff <= 24'h0;
                    state_ff <= s_setup;
                end
                s_idle:
                begin
                    if (ctrl_ff[clhp_ctl_init_bit])
                    begin
                        step_ff <= 3'h0;
                        ctl2_pass_ff <= 1'b0;
                        state_ff <= s_init_load;
                    end
                    else if (cmd_pend_ff)
                    begin
                        byte_ff <= cmd_ff[7:0];
                        sel_ff <= cmd_ff[clhp_cmd_sel_bit];
                        to_ctl2_ff <= cmd_ff[clhp_cmd_ctl2_bit] && ctrl_ff[clhp_ctl_dual_bit];
                        lo_nib_ff <= 1'b0;
                        cnt_ff <= 24'h0;
                        state_ff <= s_setup;
                    end
                end
                s_setup:
                begin
                    if (cnt_ff == 24'(clhp_setup_cyc - 1))
                    begin
                        cnt_ff <= 24'h0;
                        state_ff <= s_pulse;
                    end
                    else
                        cnt_ff <= cnt_ff + 24'h1;
                end
                s_pulse:
                begin
                    if (cnt_ff == 24'(clhp_pulse_cyc - 1))
                    begin
                        cnt_ff <= 24'h0;
                        state_ff <= s_hold;
                    end
                    else
                        cnt_ff <= cnt_ff + 24'h1;
                end
                s_hold:
                begin
                    // pins held one setup time past the falling strobe
                    if (cnt_ff == 24'(clhp_setup_cyc - 1))
                    begin
                        cnt_ff <= 24'h0;
                        if (ctrl_ff[clhp_ctl_nib_bit] && !lo_nib_ff)
                        begin
                            lo_nib_ff <= 1'b1;
                            state_ff <= s_setup;
                        end
                        else
                            state_ff <= s_wait;
                    end
                    else
                        cnt_ff <= cnt_ff + 24'h1;
                end
                s_wait:
                begin
                    if (cnt_ff >= gap_of(byte_ff, sel_ff) - 24'h1)
                    begin
                        cnt_ff <= 24'h0;
                        if (!in_init_ff)
                            state_ff <= s_idle;
                        else if (step_ff != 3'h5)
                        begin
                            step_ff <= step_ff + 3'h1;
                            state_ff <= s_init_load;
                        end
                        else if (ctrl_ff[clhp_ctl_dual_bit] && !ctl2_pass_ff)
                        begin
                            ctl2_pass_ff <= 1'b1;
                            step_ff <= 3'h0;
                            state_ff <= s_init_load;
                        end
                        else
                        begin
                            in_init_ff <= 1'b0;
                            ready_ff <= 1'b1;
                            state_ff <= s_idle;
                        end
                    end
                    else
                        cnt_ff <= cnt_ff + 24'h1;
                end
                default: state_ff <= s_power;
            endcase
        end
    end

    // ****************************************
    // pins
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            lcd_pins <= '0;
        else
        begin
            lcd_pins.instr_or_char_select <= sel_ff;
            lcd_pins.write_not_read <= 1'b0;
            // 4-bit: nibble on upper lines, lower lines left low
            if (ctrl_ff[clhp_ctl_nib_bit])
                lcd_pins.data <= lo_nib_ff ? {byte_ff[3:0], 4'h0} : {byte_ff[7:4], 4'h0};
            else
                lcd_pins.data <= byte_ff;
            lcd_pins.first_pair_strobing <= state_ff == s_pulse && !to_ctl2_ff;
            lcd_pins.second_pair_strobing <= state_ff == s_pulse && to_ctl2_ff;
        end
    end
endmodule
`default_nettype wire

// ===== sim/clhp_host_props.sv
/*
 checker of the display host: pin timing and bus answer.
 assumes it is bound to clhp_host and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module clhp_host_props
    import clhp_pkg::*;
#(
    parameter int pwr_cyc = clhp_pwr_cyc,
    parameter int slow_cyc = clhp_slow_cyc,
    parameter int fast_cyc = clhp_fast_cyc
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire clhp_pins_t lcd_pins
);
    // ****************************************
    // helper counters
    // ****************************************
    logic s;
    logic slow_ff;
    int since_ff;
    int gap_ff;
    int n_ff;
    assign s = lcd_pins.first_pair_strobing | lcd_pins.second_pair_strobing;
    // saturate so long idle runs never wrap
    always_ff @(posedge clk)
        since_ff <= sys_rst ? 0 : (since_ff < 32'hfffff ? since_ff + 1 : since_ff);
    always_ff @(posedge clk)
        gap_ff <= sys_rst ? 32'hffff : (s ? 0 : (gap_ff < 32'hffff ? gap_ff + 1 : gap_ff));
    always_ff @(posedge clk)
        slow_ff <= sys_rst ? 1'b0 : (s ? (!lcd_pins.instr_or_char_select
            && (lcd_pins.data == clhp_clear || lcd_pins.data == clhp_home)) : slow_ff);
    always_ff @(posedge clk)
        n_ff <= sys_rst ? 0 : ($rose(s) ? n_ff + 1 : n_ff);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ****************************************
    // properties
    // ****************************************
    property p_pwr_wait; $rose(s) |-> since_ff >= pwr_cyc; endproperty
    a_pwr_wait: assert property (p_pwr_wait) else $error("strobe too early");
    property p_first; $rose(s) && n_ff == 0 |-> lcd_pins.data[7:5] == 3'b001; endproperty
    a_first: assert property (p_first) else $error("first code wrong");
    property p_init_sel; s && n_ff < 6 |-> !lcd_pins.instr_or_char_select; endproperty
    a_init_sel: assert property (p_init_sel) else $error("select high in init");
    property p_write_only; !lcd_pins.write_not_read; endproperty
    a_write_only: assert property (p_write_only) else $error("direction not write");
    property p_one_strobe;
        !(lcd_pins.first_pair_strobing && lcd_pins.second_pair_strobing);
    endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("both strobes high");
    property p_width; $rose(s) |-> s[*6] ##1 !s; endproperty
    a_width: assert property (p_width) else $error("strobe width");
    property p_stable;
        s |-> $stable(lcd_pins.data) && $stable(lcd_pins.instr_or_char_select);
    endproperty
    a_stable: assert property (p_stable) else $error("pins move under strobe");
    property p_gap; $rose(s) |-> gap_ff >= (slow_ff ? slow_cyc : fast_cyc); endproperty
    a_gap: assert property (p_gap) else $error("entries too close");
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bus answer late");
    c_dual: cover property ($rose(lcd_pins.second_pair_strobing));
    c_char: cover property (s && lcd_pins.instr_or_char_select);
    c_slow: cover property ($rose(s) && slow_ff);
endmodule
bind clhp_host clhp_host_props #(.pwr_cyc(pwr_cyc), .slow_cyc(slow_cyc),
    .fast_cyc(fast_cyc)) clhp_host_props_i (.clk(clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .lcd_pins(lcd_pins));
`default_nettype wire

// ===== sim/clhp_lcd_model.sv
/*
 behavioural display module: logs each transfer, decodes controller one.
 assumes write-only pins from clhp_host.
*/
`timescale 1ns/1ns
`default_nettype none
module clhp_lcd_model
    import clhp_pkg::*;
(
    input wire clhp_pins_t pins
);
    // ****************************************
    // capture and decode
    // ****************************************
    logic [8:0] log1[$];
    logic [8:0] log2[$];
    logic nib = 1'b0;
    logic half = 1'b0;
    logic [3:0] hi = 4'h0;
    logic [6:0] addr = 7'h0;
    logic [3:0] st = 4'h0; // cursor, increment, cleared, two lines
    task automatic take(input logic rs, input logic [7:0] b);
        if (rs)
            {st[1], addr} = {1'b0, st[2] ? addr + 7'h1 : addr - 7'h1};
        else
            casez (b)
                8'b1???????: addr = b[6:0];
                8'b001?????: {nib, st[0]} = {!b[4], b[3]};
                8'b00001???: st[3] = b[1];
                8'b000001??: st[2] = b[1];
                8'h01: {st[1], addr} = {1'b1, 7'h0};
                default: ;
            endcase
    endtask
    always @(negedge pins.first_pair_strobing)
    begin
        log1.push_back({pins.instr_or_char_select, pins.data});
        if (!nib)
        begin
            take(pins.instr_or_char_select, pins.data);
            // a switch to 4-bit lands mid-byte: its lower half comes next
            {hi, half} = {pins.data[7:4], nib};
        end
        else if (!half)
            {hi, half} = {pins.data[7:4], 1'b1};
        else
        begin
            take(pins.instr_or_char_select, {hi, pins.data[7:4]});
            half = 1'b0;
        end
    end
    always @(negedge pins.second_pair_strobing)
        log2.push_back({pins.instr_or_char_select, pins.data});
endmodule
`default_nettype wire

// ===== sim/clhp_host_tb_top.sv
/*
 testbench of the display host: bus tasks and one task per scenario.
 assumes the checker and display model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module clhp_host_tb_top import clhp_pkg::*;;
    // ****************************************
    // bench
    // ****************************************
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h1;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic [31:0] q;
    clhp_pins_t pins;
    int failures = 0;
    int checks = 0;
    logic [7:0] init_seq [6] = '{8'h38, 8'h38, 8'h06, 8'h0e, 8'h01, 8'h80};
    always #20 clk = ~clk;
    clhp_host #(.pwr_cyc(20), .slow_cyc(10), .fast_cyc(4)) clhp_host_i (.clk(clk),
        .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .lcd_pins(pins));
    clhp_lcd_model clhp_lcd_model_i (.pins(pins));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        // no cycle limit here: only the watchdog ends a hung wait
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
        chk(n, 2);
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            wb(1'b0, clhp_adr_stat, 32'h0);
            n++;
        end
        while (q[1:0] !== 2'b10 && n < 500);
        chk(q[1:0], 2'b10);
    endtask
    task automatic wait_log(input int n);
        int k;
        k = 0;
        while (k < 3000 && clhp_lcd_model_i.log1.size() + clhp_lcd_model_i.log2.size() < n)
        begin
            @(posedge clk);
            k++;
        end
    endtask
    task automatic rst();
        sys_rst <= 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        clhp_lcd_model_i.log1.delete();
        clhp_lcd_model_i.log2.delete();
    endtask
    task automatic chk_init(input int c);
        for (int i = 0; i < 6; i++)
            chk(c == 1 ? clhp_lcd_model_i.log1[i] : clhp_lcd_model_i.log2[i],
                {1'b0, init_seq[i]});
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_refuse();
        rst();
        wb(1'b0, clhp_adr_ctrl, 32'h0);
        chk(q, {28'h0, clhp_ctl_rst});
        wb(1'b0, 4'hc, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, clhp_adr_cmd, 32'h14f);
        wb(1'b0, clhp_adr_stat, 32'h0);
        chk(q[2], 1'b1);
        wb(1'b1, clhp_adr_stat, 32'h4);
        wb(1'b0, clhp_adr_stat, 32'h0);
        chk(q[2], 1'b0);
    endtask
    task automatic t_init8();
        wait_ready();
        chk(clhp_lcd_model_i.log1.size(), 6);
        chk_init(1);
        chk(clhp_lcd_model_i.st, 4'hf);
        chk(clhp_lcd_model_i.addr, 7'h0);
    endtask
    task automatic t_chars();
        wb(1'b1, clhp_adr_cmd, 32'h14f);
        wait_log(7);
        chk(clhp_lcd_model_i.log1[6], 9'h14f);
        chk(clhp_lcd_model_i.addr, 7'h1);
        wait_ready();
        wb(1'b1, clhp_adr_cmd, {24'h0, clhp_addr_line2});
        wait_log(8);
        chk(clhp_lcd_model_i.addr, 7'h40);
        wait_ready();
        // software restart of the sequence: bit0 self-clears
        wb(1'b1, clhp_adr_ctrl, 32'h5);
        wait_log(9);
        wait_ready();
        chk(clhp_lcd_model_i.log1.size(), 14);
        chk(clhp_lcd_model_i.log1[8], 9'h038);
        chk(clhp_lcd_model_i.log1[13], 9'h080);
        chk(clhp_lcd_model_i.addr, 7'h0);
        wb(1'b0, clhp_adr_ctrl, 32'h0);
        chk(q, 32'h4);
    endtask
    task automatic t_dual();
        rst();
        wb(1'b1, clhp_adr_ctrl, 32'hc);
        wait_ready();
        chk_init(2);
        wb(1'b1, clhp_adr_cmd, 32'h34f);
        wait_log(13);
        chk(clhp_lcd_model_i.log2[6], 9'h14f);
        chk(clhp_lcd_model_i.log1.size(), 6);
        wait_ready();
    endtask
    task automatic t_nib();
        rst();
        wb(1'b1, clhp_adr_ctrl, 32'h6);
        wait_ready();
        chk(clhp_lcd_model_i.log1.size(), 12);
        for (int i = 0; i < clhp_lcd_model_i.log1.size(); i++)
            chk(clhp_lcd_model_i.log1[i][3:0], 4'h0);
        chk(clhp_lcd_model_i.st, 4'hf);
        clhp_lcd_model_i.log1.delete();
        wb(1'b1, clhp_adr_cmd, 32'h14f);
        wait_log(2);
        chk(clhp_lcd_model_i.log1[0], 9'h140);
        chk(clhp_lcd_model_i.log1[1], 9'h1f0);
        chk(clhp_lcd_model_i.addr, 7'h1);
        wait_ready();
    endtask
    initial
    begin
        t_refuse();
        t_init8();
        t_chars();
        t_dual();
        t_nib();
        end_of_test();
    end
    // whole run is under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        end_of_test();
    end
endmodule
`default_nettype wire
